/* src/memory_bus_priority_bridge.v */
// Memory bus arbitration per target and peripheral bus bridge
`timescale 1ns/1ns
`include "bus_bridge_map.vh"
module memory_bus_priority_bridge (
  input wire clk,
  input wire rstn,
  // Requests: index 4 data write, 3 program write, 2 data read,
  // 1 program read, 0 fetch; each names its target
  input wire [4:0] req,
  input wire [9:0] req_tgt,
  input wire [`PROG_ADDR_W-1:0] prog_addr,
  input wire [`DATA_W-1:0] prog_wdata,
  input wire [`DATA_ADDR_W-1:0] dr_addr,
  input wire [`DATA_ADDR_W-1:0] dw_addr,
  input wire [`DATA_W-1:0] dw_wdata,
  input wire [4:0] req_wide,
  input wire [1:0] req_frame,
  input wire fpc_req,
  input wire fpc_write,
  input wire fpc_wide,
  input wire [`PERIPH_ADDR_W-1:0] fpc_addr,
  input wire [`DATA_W-1:0] fpc_wdata,
  output reg [4:0] ack_reg,
  output reg [4:0] err_reg,
  output reg fpc_ack_reg,
  output reg fpc_err_reg,
  output reg [19:0] tgt_gnt_reg,
  output reg [`DATA_ADDR_W-1:0] mem_addr_reg,
  output reg [`DATA_W-1:0] mem_wdata_reg,
  output reg p_valid_reg,
  output reg p_write_reg,
  output reg p_wide_reg,
  output reg [1:0] p_frame_reg,
  output reg [`PERIPH_ADDR_W-1:0] p_addr_reg,
  output reg [`DATA_W-1:0] p_wdata_reg
);
  // ------------------------------------------------------------
  // Frame width check, used by core and coprocessor paths
  // ------------------------------------------------------------
  function frame_ok;
    input [1:0] frame;
    input wide;
    input from_fpc;
    begin
      case (frame)
        `FRAME_TWO: frame_ok = !wide && !from_fpc;
        `FRAME_ONE: frame_ok = !from_fpc;
        `FRAME_THREE: frame_ok = 1'b1;
        default: frame_ok = 1'b0;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // Per-target arbitration
  // ------------------------------------------------------------
  // Each target has its own arbiter so disjoint targets never stall
  // each other; a loser simply sees no ack and keeps its request up.
  wire [19:0] gnt_w;
  genvar t;
  generate
    for (t = 0; t < `NUM_TARGETS; t = t + 1) begin : g_tgt
      wire [4:0] treq;
      genvar r;
      for (r = 0; r < 5; r = r + 1) begin : g_req
        assign treq[r] = req[r] && (req_tgt[2*r+1:2*r] == t);
      end
      target_arbiter u_arb (
        .clk(clk),
        .rstn(rstn),
        .req(treq),
        .gnt_reg(gnt_w[5*t+4:5*t])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Grant capture and completion
  // ------------------------------------------------------------
  // Requests are registered one cycle in the arbiters; the payload is
  // sampled alongside so the ack lines up with the granted address.
  reg [4:0] req_q;
  reg [4:0] wide_q;
  reg [1:0] frame_q;
  reg [`PROG_ADDR_W-1:0] prog_addr_q;
  reg [`DATA_W-1:0] prog_wdata_q;
  reg [`DATA_ADDR_W-1:0] dr_addr_q;
  reg [`DATA_ADDR_W-1:0] dw_addr_q;
  reg [`DATA_W-1:0] dw_wdata_q;
  reg fpc_q;
  reg fpc_write_q;
  reg fpc_wide_q;
  reg [`PERIPH_ADDR_W-1:0] fpc_addr_q;
  reg [`DATA_W-1:0] fpc_wdata_q;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      req_q <= 5'h00;
      wide_q <= 5'h00;
      frame_q <= 2'h0;
      prog_addr_q <= 22'h000000;
      prog_wdata_q <= 32'h00000000;
      dr_addr_q <= 32'h00000000;
      dw_addr_q <= 32'h00000000;
      dw_wdata_q <= 32'h00000000;
      fpc_q <= 1'b0;
      fpc_write_q <= 1'b0;
      fpc_wide_q <= 1'b0;
      fpc_addr_q <= 16'h0000;
      fpc_wdata_q <= 32'h00000000;
    end else begin
      req_q <= req;
      wide_q <= req_wide;
      frame_q <= req_frame;
      prog_addr_q <= prog_addr;
      prog_wdata_q <= prog_wdata;
      dr_addr_q <= dr_addr;
      dw_addr_q <= dw_addr;
      dw_wdata_q <= dw_wdata;
      fpc_q <= fpc_req;
      fpc_write_q <= fpc_write;
      fpc_wide_q <= fpc_wide;
      fpc_addr_q <= fpc_addr;
      fpc_wdata_q <= fpc_wdata;
    end
  end

  // Granted set across all targets
  wire [4:0] won = gnt_w[4:0] | gnt_w[9:5] | gnt_w[14:10] | gnt_w[19:15];
  wire [4:0] p_won = gnt_w[19:15];
  // Core wins the peripheral bus over the coprocessor
  wire fpc_won = fpc_q && (p_won == 5'h00);

  reg [4:0] ack_next;
  reg [4:0] err_next;
  reg fpc_ack_next;
  reg fpc_err_next;
  reg [`DATA_ADDR_W-1:0] mem_addr_next;
  reg [`DATA_W-1:0] mem_wdata_next;
  reg p_valid_next;
  reg p_write_next;
  reg p_wide_next;
  reg [1:0] p_frame_next;
  reg [`PERIPH_ADDR_W-1:0] p_addr_next;
  reg [`DATA_W-1:0] p_wdata_next;
  reg [`DATA_ADDR_W-1:0] sel_addr;
  reg [`DATA_W-1:0] sel_wdata;
  reg sel_ok;
  always @* begin
    ack_next = won & req_q;
    err_next = 5'h00;
    fpc_ack_next = 1'b0;
    fpc_err_next = 1'b0;
    p_valid_next = 1'b0;
    p_write_next = 1'b0;
    p_wide_next = 1'b0;
    p_frame_next = `FRAME_NONE;
    p_addr_next = p_addr_reg;
    p_wdata_next = p_wdata_reg;
    sel_addr = 32'h00000000;
    sel_wdata = 32'h00000000;
    sel_ok = 1'b0;
    // Memory-side address follows the highest-priority winner among data write, program write and data read; write data follows only the two writes
    mem_addr_next = mem_addr_reg;
    mem_wdata_next = mem_wdata_reg;
    if (won[4]) begin
      mem_addr_next = dw_addr_q;
      mem_wdata_next = dw_wdata_q;
    end else if (won[3]) begin
      mem_addr_next = {10'h000, prog_addr_q};
      mem_wdata_next = prog_wdata_q;
    end else if (won[2]) begin
      mem_addr_next = dr_addr_q;
    end
    // Peripheral bridge: one winner per cycle onto the bus with 16-bit address and 32-bit data
    if (p_won != 5'h00) begin
      case (p_won)
        `GNT_DW: begin
          sel_addr = dw_addr_q;
          sel_wdata = dw_wdata_q;
        end
        `GNT_PW: begin
          sel_addr = {10'h000, prog_addr_q};
          sel_wdata = prog_wdata_q;
        end
        `GNT_DR: sel_addr = dr_addr_q;
        default: sel_addr = {10'h000, prog_addr_q};
      endcase
      sel_ok = frame_ok(frame_q, |(p_won & wide_q), 1'b0);
      if (sel_ok) begin
        p_valid_next = 1'b1;
        p_write_next = |(p_won & `GNT_DW) || |(p_won & `GNT_PW);
        p_wide_next = |(p_won & wide_q);
        p_frame_next = frame_q;
        p_addr_next = sel_addr[`PERIPH_ADDR_W-1:0];
        p_wdata_next = sel_wdata;
      end else begin
        // A refused access must not also look served to the core
        ack_next = ack_next & ~p_won;
        err_next = p_won;
      end
    end else if (fpc_won) begin
      // The coprocessor shares the frame select; only frame three lets it in
      if (frame_ok(frame_q, fpc_wide_q, 1'b1)) begin
        p_valid_next = 1'b1;
        p_write_next = fpc_write_q;
        p_wide_next = fpc_wide_q;
        p_frame_next = `FRAME_THREE;
        p_addr_next = fpc_addr_q;
        p_wdata_next = fpc_wdata_q;
        fpc_ack_next = 1'b1;
      end else begin
        fpc_err_next = 1'b1;
      end
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 5'h00;
      err_reg <= 5'h00;
      fpc_ack_reg <= 1'b0;
      fpc_err_reg <= 1'b0;
      tgt_gnt_reg <= 20'h00000;
      mem_addr_reg <= 32'h00000000;
      mem_wdata_reg <= 32'h00000000;
      p_valid_reg <= 1'b0;
      p_write_reg <= 1'b0;
      p_wide_reg <= 1'b0;
      p_frame_reg <= 2'h0;
      p_addr_reg <= 16'h0000;
      p_wdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= ack_next;
      err_reg <= err_next;
      fpc_ack_reg <= fpc_ack_next;
      fpc_err_reg <= fpc_err_next;
      tgt_gnt_reg <= gnt_w;
      mem_addr_reg <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
      p_valid_reg <= p_valid_next;
      p_write_reg <= p_write_next;
      p_wide_reg <= p_wide_next;
      p_frame_reg <= p_frame_next;
      p_addr_reg <= p_addr_next;
      p_wdata_reg <= p_wdata_next;
    end
  end
endmodule

/* src/bus_bridge_map.vh */
// Constants for the memory bus arbiter and peripheral bridge
`ifndef BUS_BRIDGE_MAP_VH
`define BUS_BRIDGE_MAP_VH
`define PROG_ADDR_W 22
`define DATA_ADDR_W 32
`define DATA_W 32
`define PERIPH_ADDR_W 16
`define NUM_TARGETS 4
`define TGT_SEL_W 2
// Grant encodings, one-hot per requester
`define GNT_DW 5'h10
`define GNT_PW 5'h08
`define GNT_DR 5'h04
`define GNT_PR 5'h02
`define GNT_FE 5'h01
`define GNT_NONE 5'h00
// Peripheral frame codes
`define FRAME_NONE 2'h0
`define FRAME_ONE 2'h1
`define FRAME_TWO 2'h2
`define FRAME_THREE 2'h3
// Index of the target that is the peripheral bridge
`define TGT_PERIPH 2'h3
`endif

/* src/target_arbiter.v */
// Fixed-priority arbiter for one memory or peripheral target
`timescale 1ns/1ns
`include "bus_bridge_map.vh"
module target_arbiter (
  input wire clk,
  input wire rstn,
  input wire [4:0] req,
  output reg [4:0] gnt_reg
);
  // ------------------------------------------------------------
  // Priority pick
  // ------------------------------------------------------------
  reg [4:0] gnt_next;
  always @* begin
    // Order: data write, program write, data read, program read, fetch
    if (req[4]) begin
      gnt_next = `GNT_DW;
    end else if (req[3]) begin
      gnt_next = `GNT_PW;
    end else if (req[2]) begin
      gnt_next = `GNT_DR;
    end else if (req[1]) begin
      gnt_next = `GNT_PR;
    end else if (req[0]) begin
      gnt_next = `GNT_FE;
    end else begin
      gnt_next = `GNT_NONE;
    end
  end
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gnt_reg <= 5'h00;
    end else begin
      gnt_reg <= gnt_next;
    end
  end
endmodule

/* tb/bridge_props.sv */
// Assertions on the arbiter and peripheral bridge ports
`timescale 1ns/1ns
module bridge_props (
  input wire clk,
  input wire rstn,
  input wire [4:0] req,
  input wire [9:0] req_tgt,
  input wire [21:0] prog_addr,
  input wire [31:0] dw_addr,
  input wire [4:0] req_wide,
  input wire [1:0] req_frame,
  input wire fpc_req,
  input wire [4:0] ack_reg,
  input wire [4:0] err_reg,
  input wire fpc_ack_reg,
  input wire p_valid_reg,
  input wire p_wide_reg,
  input wire [1:0] p_frame_reg,
  input wire [31:0] mem_addr_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire [4:0] done = ack_reg | err_reg;
  wire [1:0] t4 = req_tgt[9:8];
  wire [1:0] t3 = req_tgt[7:6];
  wire [1:0] t2 = req_tgt[5:4];
  wire [1:0] t1 = req_tgt[3:2];
  wire [1:0] t0 = req_tgt[1:0];
  sequence s_dr_periph(f);
    req == 5'h04 && t2 == 2'h3 && req_frame == f && req_wide[2];
  endsequence
  sequence s_dr_lost;
    req[4] && req[2] && t4 == t2;
  endsequence
  a_dw_served: assert property (req[4] |-> ##2 done[4])
    else $error("data write not served");
  a_pw_over_dr: assert property (req[3] && req[2] && t3 == t2 |-> ##2 done[3] && !done[2])
    else $error("program write lost");
  a_dr_over_pr: assert property (req[2] && req[1] && t2 == t1 |-> ##2 done[2] && !done[1])
    else $error("data read lost");
  a_fetch_last: assert property (req[0] && req[2] && t2 == t0 |-> ##2 !done[0])
    else $error("fetch won a conflict");
  a_loser_held: assert property (s_dr_lost ##1 req == 5'h04 |-> ##2 ack_reg == 5'h04)
    else $error("held read not served");
  a_targets_apart: assert property (req == 5'h15 && t4 != t2 && t2 != t0 && t4 != t0 |-> ##2 done == 5'h15)
    else $error("independent targets stalled");
  a_frame_two: assert property (s_dr_periph(2'h2) |-> ##2 err_reg[2] && !p_valid_reg)
    else $error("wide access taken on frame two");
  a_frame_one: assert property (s_dr_periph(2'h1) |-> ##2 p_valid_reg && p_wide_reg && p_frame_reg == 2'h1)
    else $error("wide access lost on frame one");
  a_fpc_frame: assert property (fpc_req && req == 5'h00 && req_frame == 2'h3 |-> ##2 fpc_ack_reg && p_valid_reg)
    else $error("coprocessor access lost");
  a_dw_addr: assert property (req[4] && t4 != 2'h3 |-> ##2 mem_addr_reg == $past(dw_addr, 2))
    else $error("write address wrong");
  a_refused_unacked: assert property ((ack_reg & err_reg) == 5'h00)
    else $error("refused access acknowledged");
endmodule
bind memory_bus_priority_bridge bridge_props u_props (.clk, .rstn, .req, .req_tgt, .prog_addr,
  .dw_addr, .req_wide, .req_frame, .fpc_req, .ack_reg, .err_reg, .fpc_ack_reg, .p_valid_reg,
  .p_wide_reg, .p_frame_reg, .mem_addr_reg);

/* tb/periph_model.sv */
// Peripheral side: counts bus cycles and keeps the last address
`timescale 1ns/1ns
module periph_model (
  input wire clk,
  input wire rstn,
  input wire p_valid_reg,
  input wire [15:0] p_addr_reg,
  output reg [7:0] n_seen,
  output reg [15:0] last_addr
);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      n_seen <= 8'h00;
      last_addr <= 16'h0000;
    end else if (p_valid_reg) begin
      n_seen <= n_seen + 8'h01;
      last_addr <= p_addr_reg;
    end
  end
endmodule

/* tb/memory_bus_priority_bridge_test.sv */
// Self-checking bench for the memory bus arbiter and bridge
`timescale 1ns/1ns
module memory_bus_priority_bridge_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] req = 5'h00;
  logic [9:0] req_tgt = 10'h155;
  logic [21:0] prog_addr = 22'h3fffff;
  logic [31:0] prog_wdata = 32'h5a5a0f0f;
  logic [31:0] dr_addr = 32'hc0de1234;
  logic [31:0] dw_addr = 32'h8765abcd;
  logic [31:0] dw_wdata = 32'h13572468;
  logic [4:0] req_wide = 5'h00;
  logic [1:0] req_frame = 2'h0;
  logic fpc_req = 1'b0;
  logic fpc_write = 1'b1;
  logic fpc_wide = 1'b1;
  logic [15:0] fpc_addr = 16'h0abc;
  logic [31:0] fpc_wdata = 32'hfeedf00d;
  wire [4:0] ack_reg, err_reg;
  wire fpc_ack_reg, fpc_err_reg, p_valid_reg, p_wide_reg;
  wire [31:0] mem_addr_reg;
  wire [31:0] mem_wdata_reg, p_wdata_reg;
  wire [19:0] tgt_gnt_reg;
  wire p_write_reg;
  logic [19:0] gnt_seen;
  wire [1:0] p_frame_reg;
  wire [15:0] p_addr_reg, last_addr;
  wire [7:0] n_seen;
  int n_fail = 0;
  int checked = 0;
  logic [7:0] n0;
  always #4 clk = ~clk;
  memory_bus_priority_bridge i_dut (.clk, .rstn, .req, .req_tgt, .prog_addr, .prog_wdata,
    .dr_addr, .dw_addr, .dw_wdata, .req_wide, .req_frame, .fpc_req, .fpc_write, .fpc_wide,
    .fpc_addr, .fpc_wdata, .ack_reg, .err_reg, .fpc_ack_reg, .fpc_err_reg, .tgt_gnt_reg,
    .mem_addr_reg, .mem_wdata_reg, .p_valid_reg, .p_write_reg, .p_wide_reg, .p_frame_reg,
    .p_addr_reg, .p_wdata_reg);
  periph_model i_periph (.clk, .rstn, .p_valid_reg, .p_addr_reg, .n_seen, .last_addr);
  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Answer comes two edges after the request is driven; e1 and e2 are {err, ack}
  task automatic cyc(input [4:0] r1, input [4:0] r2, input [9:0] e1, input [9:0] e2);
    @(posedge clk) req <= r1;
    @(posedge clk) req <= r2;
    @(posedge clk) req <= 5'h00;
    #1 chk(32'({err_reg, ack_reg}), 32'(e1));
    gnt_seen = tgt_gnt_reg;
    @(posedge clk) #1 chk(32'({err_reg, ack_reg}), 32'(e2));
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_prio;
    for (int h = 4; h > 0; h--) for (int l = h - 1; l >= 0; l--)
      if (!(h == 4 && l == 3) && h != 1)
        cyc((5'h01 << h) | (5'h01 << l), 5'h01 << l, 10'(5'h01 << h), 10'(5'h01 << l));
    $display("priority test ended");
  endtask
  task automatic t_conc;
    @(posedge clk) req_tgt <= 10'h012;
    cyc(5'h15, 5'h00, 10'h015, 10'h000);
    chk(mem_addr_reg, dw_addr);
    chk(mem_wdata_reg, dw_wdata);
    chk(32'(gnt_seen), 32'h00000490);
    @(posedge clk) req_tgt <= 10'h040;
    cyc(5'h08, 5'h00, 10'h008, 10'h000);
    chk(mem_addr_reg, {10'h000, prog_addr});
    chk(mem_wdata_reg, prog_wdata);
    $display("concurrency test ended");
  endtask
  task automatic t_frames;
    logic ok;
    @(posedge clk) req_tgt <= 10'h030;
    for (int f = 0; f < 4; f++) for (int w = 0; w < 2; w++) begin
      ok = f != 0 && !(f == 2 && w == 1);
      @(posedge clk) begin
        req_frame <= 2'(f);
        req_wide <= {2'b00, w[0], 2'b00};
        n0 = n_seen;
      end
      cyc(5'h04, 5'h00, ok ? 10'h004 : 10'h080, 10'h000);
      chk(32'(n_seen - n0), {31'h0, ok});
      if (ok) chk(32'(last_addr), {16'h0000, dr_addr[15:0]});
    end
    $display("frame test ended");
  endtask
  task automatic t_fpc;
    @(posedge clk) begin
      fpc_req <= 1'b1;
      req_frame <= 2'h3;
      req <= 5'h04;
    end
    @(posedge clk) req <= 5'h00;
    @(posedge clk) fpc_req <= 1'b0;
    #1 chk({ack_reg, fpc_ack_reg}, 32'h8);
    @(posedge clk) #1 chk({ack_reg, fpc_ack_reg}, 32'h1);
    chk({p_valid_reg, p_write_reg, p_wide_reg, p_frame_reg}, 32'h1f);
    chk(p_wdata_reg, fpc_wdata);
    chk(32'(p_addr_reg), {16'h0000, fpc_addr});
    @(posedge clk) begin
      fpc_req <= 1'b1;
      req_frame <= 2'h1;
    end
    @(posedge clk) fpc_req <= 1'b0;
    @(posedge clk) #1 chk({fpc_err_reg, fpc_ack_reg}, 32'h2);
    $display("coprocessor test ended");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_prio();
    t_conc();
    t_frames();
    t_fpc();
    print_verdict();
  end
endmodule
